// file: pkg/scp_defs.svh
/*
  constants of the serial configuration port: register addresses, field
  positions, word framing and link timing.
  assumes inclusion by bare name from the device and host design files.
*/
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_ADDR_CTRL 8'h00
`define SCP_ADDR_PWR 8'h35
`define SCP_ADDR_GAIN 8'h3B
`define SCP_RESET_VAL 16'h0000
`define SCP_BIT_SOFT_RESET 0
`define SCP_BIT_READBACK 1
`define SCP_BIT_FULL_SLEEP 15
`define SCP_BIT_HALF_SLEEP 14
`define SCP_BIT_NARROW_BAND 7
`define SCP_GAIN_HI 6
`define SCP_GAIN_LO 4
`define SCP_WORD_BITS 24
`define SCP_ADDR_BITS 8
`define SCP_DATA_BITS 16
`define SCP_CLK_NS 4
`define SCP_SCLK_MIN_NS 50
`define SCP_HALF_CYCLES ((`SCP_SCLK_MIN_NS + 2 * `SCP_CLK_NS - 1) / (2 * `SCP_CLK_NS))
`define SCP_HOST_ADDR_CMD 2'h0
`define SCP_HOST_ADDR_DATA 2'h1
`define SCP_HOST_ADDR_STAT 2'h2
`endif

// file: pkg/scp_if.sv
/*
  four-wire serial link between host and device plus the device's hardware reset pin.
  assumes the bench drives the pull levels when nobody drives a pin.
*/
`default_nettype none
interface scp_if;
  logic serial_select_n;
  logic shift_clock;
  logic serial_input_line;
  logic serial_output_line;
  logic hw_reset_pin;
  modport device (input serial_select_n, input shift_clock, input serial_input_line,
                  input hw_reset_pin, output serial_output_line);
  modport host (output serial_select_n, output shift_clock, output serial_input_line,
                output hw_reset_pin, input serial_output_line);
endinterface
`default_nettype wire

// file: pkg/scp_pkg.sv
/*
  types shared by both ends of the serial configuration port.
  assumes scp_defs.svh on the include path.
*/
`default_nettype none
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_H_IDLE = 2'h0,
    SCP_H_LOW = 2'h1,
    SCP_H_HIGH = 2'h3,
    SCP_H_END = 2'h2
  } scp_host_state_t;
  typedef logic [15:0] scp_word_t;
endpackage
`default_nettype wire

// file: rtl/scp_device.sv
/*
  device end of the serial configuration port: shifts 24-bit words,
  holds three 16-bit registers, answers readback and decodes controls.
  assumes all link pins are asynchronous to clk and that the link clock is
  far slower than clk.
*/
// Decided for this implementation: the address-and-strobe port.
// Operation
// - sample input on shift rising edges while selected
// - load register on every 24th rising edge
// - count groups of 24 from select fall
// - discard leftover bits, no update
// - word is 8 address then 16 data
// - host shift clock up to 20 MHz
// - host writes zero to unused bits
// - readback bit enables serial output of register
// - output changes after shift falling edge
// - readback bit stays writable; clear restores writes
// - reset pin pulse resets the device
// - soft reset bit clears all, self-clears
// - registers kept during power-down
// - bit15 full sleep, bit14 half sleep
// - partial sleep pin sleeps whole device; here the pin sets half_sleep only
// - select active low, pulled up
// - reset high: input line picks narrow band
// - gain code 000 18 dB, 3 dB steps
// - serial control only with reset low
// - gain bits 6:4, band bit 7
`default_nettype none
`include "scp_defs.svh"
module scp_device
  import scp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  scp_if.device link,
  // strap pins
  input wire logic partial_sleep_pin,
  input wire logic [2:0] gain_pins,
  // analog controls
  output logic [2:0] gain_code_field,
  output logic [4:0] gain_atten_db,
  output logic narrow_band_select,
  output logic full_sleep,
  output logic half_sleep,
  output logic readback_on
);
  logic sel_n_s, sclk_s, sdi_s, rst_s, pdn_s;
  logic [2:0] gpin_s;
  logic sclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [22:0] shift_r;
  scp_word_t ctrl_r, pwr_r, gain_r;
  scp_word_t out_sh_r;
  logic sdo_r;
  logic rise, fall, word_done, sw_rst, wr_ok, clr_all;
  logic [7:0] w_addr, rb_addr;
  logic [2:0] gain_sel;
  logic [4:0] atten_nxt;
  scp_word_t w_data, rd_val;

  // every pin crosses two flops; select starts high so reset opens no frame
  scp_sync #(.INIT(1'b1)) u_sel (.clk(clk), .reset(reset), .async_in(link.serial_select_n),
    .sync_out(sel_n_s));
  scp_sync u_sclk (.clk(clk), .reset(reset), .async_in(link.shift_clock), .sync_out(sclk_s));
  scp_sync u_sdi (.clk(clk), .reset(reset), .async_in(link.serial_input_line),
    .sync_out(sdi_s));
  scp_sync u_rst (.clk(clk), .reset(reset), .async_in(link.hw_reset_pin), .sync_out(rst_s));
  scp_sync u_pdn (.clk(clk), .reset(reset), .async_in(partial_sleep_pin), .sync_out(pdn_s));
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_gain
      scp_sync u_g (.clk(clk), .reset(reset), .async_in(gain_pins[gi]),
        .sync_out(gpin_s[gi]));
    end
  endgenerate

  // idles low like the pulled-down shift clock, so reset leaves no false edge
  always_ff @(posedge clk) begin
    if (reset) sclk_d_r <= 1'b0;
    else sclk_d_r <= sclk_s;
  end
  assign rise = sclk_s & ~sclk_d_r & ~sel_n_s;
  assign fall = ~sclk_s & sclk_d_r & ~sel_n_s;
  assign word_done = rise && bit_cnt_r == 5'(`SCP_WORD_BITS - 1);
  // only 23 bits are kept; the last one is taken straight from the line
  assign w_addr = shift_r[22:15];
  assign w_data = {shift_r[14:0], sdi_s};
  assign rb_addr = {shift_r[6:0], sdi_s};
  // write of soft reset while writes are permitted
  assign sw_rst = word_done && !rst_s && !ctrl_r[`SCP_BIT_READBACK] &&
    w_addr == `SCP_ADDR_CTRL && w_data[`SCP_BIT_SOFT_RESET];
  // with readback on only the control word may land
  assign wr_ok = word_done && !rst_s && !ctrl_r[`SCP_BIT_READBACK];
  // pin and soft reset clear the three registers, as the system reset does
  assign clr_all = reset || sw_rst || rst_s;

  // counter restarts on every select fall, so a partial group is dropped
  always_ff @(posedge clk) begin
    if (reset || sel_n_s) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 23'h000000;
    end else if (rise) begin
      shift_r <= {shift_r[21:0], sdi_s};
      bit_cnt_r <= word_done ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  // control word: soft reset bit never sticks, readback bit stays writable
  always_ff @(posedge clk) begin
    if (clr_all) begin
      ctrl_r <= `SCP_RESET_VAL;
    end else if (word_done && w_addr == `SCP_ADDR_CTRL) begin
      ctrl_r <= w_data & 16'h0002;
    end
  end

  // sleep bits only gate the analog side, so settings survive power-down
  always_ff @(posedge clk) begin
    if (clr_all) begin
      pwr_r <= `SCP_RESET_VAL;
    end else if (wr_ok && w_addr == `SCP_ADDR_PWR) begin
      pwr_r <= w_data;
    end
  end

  always_ff @(posedge clk) begin
    if (clr_all) begin
      gain_r <= `SCP_RESET_VAL;
    end else if (wr_ok && w_addr == `SCP_ADDR_GAIN) begin
      gain_r <= w_data;
    end
  end

  // address seen at the 8th rise picks the word sent back; unknown ones read 0
  always_comb begin
    case (rb_addr)
      `SCP_ADDR_CTRL: rd_val = ctrl_r;
      `SCP_ADDR_PWR: rd_val = pwr_r;
      `SCP_ADDR_GAIN: rd_val = gain_r;
      default: rd_val = 16'h0000;
    endcase
  end

  // readback: address complete after 8 rises, data leaves on falling edges
  always_ff @(posedge clk) begin
    if (reset || sel_n_s) begin
      out_sh_r <= 16'h0000;
      sdo_r <= 1'b0;
    end else if (rise && bit_cnt_r == 5'(`SCP_ADDR_BITS - 1)) begin
      out_sh_r <= ctrl_r[`SCP_BIT_READBACK] ? rd_val : 16'h0000;
    end else if (fall && bit_cnt_r >= 5'(`SCP_ADDR_BITS)) begin
      sdo_r <= out_sh_r[15];
      out_sh_r <= {out_sh_r[14:0], 1'b0};
    end
  end
  assign link.serial_output_line = sdo_r;

  // pins win while the hardware reset pin is high
  assign gain_sel = rst_s ? gpin_s : gain_r[`SCP_GAIN_HI:`SCP_GAIN_LO];

  // attenuation ahead of the fixed 18 dB stage; code 7 is unused and read as 0 dB gain
  always_comb begin
    case (gain_sel)
      3'h0: atten_nxt = 5'h00;
      3'h1: atten_nxt = 5'h03;
      3'h2: atten_nxt = 5'h06;
      3'h3: atten_nxt = 5'h09;
      3'h4: atten_nxt = 5'h0C;
      3'h5: atten_nxt = 5'h0F;
      3'h6: atten_nxt = 5'h12;
      default: atten_nxt = 5'h12;
    endcase
  end

  // outputs, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_code_field <= 3'h0;
      gain_atten_db <= 5'h00;
    end else begin
      gain_code_field <= gain_sel;
      gain_atten_db <= atten_nxt;
    end
  end

  // band follows the input line itself while the reset pin is high
  always_ff @(posedge clk) begin
    if (reset) narrow_band_select <= 1'b0;
    else narrow_band_select <= rst_s ? sdi_s : gain_r[`SCP_BIT_NARROW_BAND];
  end

  // the sleep pin forces partial sleep without touching the stored bits
  always_ff @(posedge clk) begin
    if (reset) begin
      full_sleep <= 1'b0;
      half_sleep <= 1'b0;
      readback_on <= 1'b0;
    end else begin
      full_sleep <= pwr_r[`SCP_BIT_FULL_SLEEP];
      half_sleep <= pwr_r[`SCP_BIT_HALF_SLEEP] | pdn_s;
      readback_on <= ctrl_r[`SCP_BIT_READBACK];
    end
  end
endmodule // scp_device
`default_nettype wire

// file: rtl/scp_host.sv
/*
  host end: runs one 24-bit serial word per command and captures readback.
  assumes a software port on clk; the shift clock is made here by a divider.
*/
`default_nettype none
`include "scp_defs.svh"
module scp_host
  import scp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  scp_if.host link,
  // software port
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  scp_host_state_t st_r;
  logic [23:0] tx_r;
  logic [4:0] bits_r;
  logic [4:0] div_r;
  logic [15:0] rx_r;
  logic reset_pin_r, sel_n_r, sclk_r, sdo_r, busy;
  logic sdi_s;
  logic [23:0] cmd_r;

  scp_sync u_sdi (.clk(clk), .reset(reset), .async_in(link.serial_output_line),
    .sync_out(sdi_s));
  assign busy = st_r != SCP_H_IDLE;

  // software writes; a command write starts a word
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_r <= 24'h000000;
      reset_pin_r <= 1'b0;
    end else if (wr && addr == `SCP_HOST_ADDR_CMD && !busy) begin
      cmd_r <= wdata[23:0];
    end else if (wr && addr == `SCP_HOST_ADDR_STAT) begin
      reset_pin_r <= wdata[1];
    end
  end

  // shift clock divider, half period rounded up to meet the 50 ns minimum
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= SCP_H_IDLE;
      div_r <= 5'h00;
      bits_r <= 5'h00;
      tx_r <= 24'h000000;
      sel_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sdo_r <= 1'b0;
      rx_r <= 16'h0000;
    end else begin
      case (st_r)
        SCP_H_IDLE: if (wr && addr == `SCP_HOST_ADDR_CMD) begin
          tx_r <= {wdata[22:0], 1'b0};
          sdo_r <= wdata[23];
          sel_n_r <= 1'b0;
          bits_r <= 5'h00;
          div_r <= 5'h00;
          st_r <= SCP_H_LOW;
        end
        SCP_H_LOW: if (div_r == 5'(`SCP_HALF_CYCLES - 1)) begin
          div_r <= 5'h00;
          sclk_r <= 1'b1;
          st_r <= SCP_H_HIGH;
        end else div_r <= div_r + 5'h01;
        SCP_H_HIGH: if (div_r == 5'(`SCP_HALF_CYCLES - 1)) begin
          div_r <= 5'h00;
          sclk_r <= 1'b0;
          if (bits_r >= 5'(`SCP_ADDR_BITS)) rx_r <= {rx_r[14:0], sdi_s};
          if (bits_r == 5'(`SCP_WORD_BITS - 1)) st_r <= SCP_H_END;
          else begin
            bits_r <= bits_r + 5'h01;
            sdo_r <= tx_r[23];
            tx_r <= {tx_r[22:0], 1'b0};
            st_r <= SCP_H_LOW;
          end
        end else div_r <= div_r + 5'h01;
        SCP_H_END: if (div_r == 5'(`SCP_HALF_CYCLES - 1)) begin
          sel_n_r <= 1'b1;
          sdo_r <= 1'b0;
          st_r <= SCP_H_IDLE;
        end else div_r <= div_r + 5'h01;
        default: st_r <= SCP_H_IDLE;
      endcase
    end
  end
  assign link.serial_select_n = sel_n_r;
  assign link.shift_clock = sclk_r;
  assign link.serial_input_line = sdo_r;
  assign link.hw_reset_pin = reset_pin_r;

  always_ff @(posedge clk) begin
    if (reset) rdata <= 32'h00000000;
    else if (rd) begin
      case (addr)
        `SCP_HOST_ADDR_CMD: rdata <= {8'h00, cmd_r};
        `SCP_HOST_ADDR_DATA: rdata <= {16'h0000, rx_r};
        `SCP_HOST_ADDR_STAT: rdata <= {30'h00000000, reset_pin_r, busy};
        default: rdata <= 32'h00000000;
      endcase
    end else rdata <= 32'h00000000;
  end
endmodule // scp_host
`default_nettype wire

// file: rtl/scp_sync.sv
/*
  two flip-flop synchroniser for one asynchronous level.
  assumes a synchronous active-high reset on the receiving clock.
*/
`default_nettype none
module scp_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // scp_sync

// file: test/scp_checker_assertions.sv
/*
  concurrent checks on the serial link between host and device.
  assumes the link is sampled on the clk that both ends share.
*/
`default_nettype none
module scp_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  input wire logic serial_select_n,
  input wire logic shift_clock,
  input wire logic serial_input_line,
  input wire logic serial_output_line,
  input wire logic hw_reset_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic sclk_q_r;
  logic [4:0] edges_r;
  always_ff @(posedge clk) begin
    if (reset) sclk_q_r <= 1'b0;
    else sclk_q_r <= shift_clock;
  end
  // rising edges seen in the current select window
  always_ff @(posedge clk) begin
    if (reset || serial_select_n) edges_r <= 5'h00;
    else if (shift_clock && !sclk_q_r) edges_r <= edges_r + 5'h01;
  end
  a_word_edge_count: assert property ($rose(serial_select_n) |-> edges_r == 5'h18)
    else $error("select window did not hold 24 rising edges");
  a_out_idle_low: assert property (serial_select_n [*4] |-> !serial_output_line)
    else $error("output line not low while deselected");
  a_out_fall_phase: assert property ($changed(serial_output_line) |->
    (!shift_clock || serial_select_n))
    else $error("output line changed while shift clock high");
  a_clk_still_idle: assert property (serial_select_n [*8] |=> $stable(shift_clock))
    else $error("shift clock moved outside a frame");
  a_high_time: assert property ($rose(shift_clock) |-> shift_clock [*5])
    else $error("shift clock high phase too short");
  a_low_time: assert property ($fell(shift_clock) |-> !shift_clock [*5])
    else $error("shift clock low phase too short");
  a_data_held: assert property ($rose(shift_clock) |->
    $stable(serial_input_line) ##1 $stable(serial_input_line))
    else $error("input line moved at a rising edge");
  a_select_setup: assert property ($fell(serial_select_n) |-> !shift_clock [*2])
    else $error("shift clock rose too soon after select");
  a_select_hold: assert property ($rose(shift_clock) |-> !serial_select_n [*3])
    else $error("select released too soon after a rising edge");
  c_frame: cover property ($rose(serial_select_n));
  c_readback: cover property ($rose(serial_output_line));
  c_hw_pin: cover property ($rose(hw_reset_pin));
endmodule // scp_checker
`default_nettype wire

// file: test/tb_serial_config_port.sv
/*
  testbench: software port drives the host, device outputs are compared.
  assumes both ends share clk and reset.
*/
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_serial_config_port;
  timeunit 1ns;
  timeprecision 100ps;
  import scp_pkg::*;
  logic clk, reset, partial_sleep_pin, wr, rd;
  logic [2:0] gain_pins, gain_code_field;
  logic [1:0] addr;
  logic [31:0] wdata, rdata, s;
  logic [4:0] gain_atten_db, e;
  logic narrow_band_select, full_sleep, half_sleep, readback_on;
  int fail_count = 0;
  int num_checks = 0;
  scp_if scp_if_i();
  scp_device scp_device_i(.clk(clk), .reset(reset), .link(scp_if_i.device),
    .partial_sleep_pin(partial_sleep_pin), .gain_pins(gain_pins),
    .gain_code_field(gain_code_field), .gain_atten_db(gain_atten_db),
    .narrow_band_select(narrow_band_select), .full_sleep(full_sleep),
    .half_sleep(half_sleep), .readback_on(readback_on));
  scp_host scp_host_i(.clk(clk), .reset(reset), .link(scp_if_i.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  scp_checker scp_checker_i(.clk(clk), .reset(reset),
    .serial_select_n(scp_if_i.serial_select_n), .shift_clock(scp_if_i.shift_clock),
    .serial_input_line(scp_if_i.serial_input_line),
    .serial_output_line(scp_if_i.serial_output_line), .hw_reset_pin(scp_if_i.hw_reset_pin));
  always #2 clk = ~clk;
  task automatic wr_port(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_port(input logic [1:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // wait for busy to drop under a bound; a hang ends the run as a mismatch
  task automatic wait_idle;
    int n;
    n = 0;
    do begin rd_port(2'h2, s); n++; end while (s[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      fail_count++;
      test_done();
    end else repeat (8) @(posedge clk);
  endtask
  // one serial word
  task automatic send(input logic [7:0] a, input logic [15:0] d);
    wr_port(2'h0, {8'h00, a, d});
    wait_idle();
  endtask
  task automatic chk_gain(input logic [2:0] c);
    e = (c == 3'h7) ? 5'h12 : 5'(c * 3);
    `CHK("gain", c, gain_code_field)
    `CHK("atten", e, gain_atten_db)
  endtask
  task automatic test_done;
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial begin
    clk = 0; reset = 1; partial_sleep_pin = 0; gain_pins = 3'h3;
    addr = 2'h0; wdata = 32'h0; wr = 0; rd = 0;
    repeat (8) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    #1 `CHK("pwr", 2'h0, {full_sleep, half_sleep})
    chk_gain(3'h0);
    for (int c = 0; c < 8; c++) begin
      send(8'h3B, {8'h00, c[0], c[2:0], 4'h0});
      chk_gain(c[2:0]);
      `CHK("band", c[0], narrow_band_select)
    end
    send(8'h35, 16'hC000);
    `CHK("sleep", 2'h3, {full_sleep, half_sleep})
    chk_gain(3'h7);
    send(8'h35, 16'h4000);
    `CHK("sleep", 2'h1, {full_sleep, half_sleep})
    send(8'h35, 16'h0000);
    partial_sleep_pin <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("pin sleep", 1'b1, half_sleep)
    partial_sleep_pin <= 1'b0;
    send(8'h12, 16'h0000);
    chk_gain(3'h7);
    send(8'h00, 16'h0002);
    `CHK("readback", 1'b1, readback_on)
    send(8'h3B, 16'h0030);
    rd_port(2'h1, s);
    `CHK("read data", 16'h00F0, s[15:0])
    chk_gain(3'h7);
    send(8'h00, 16'h0000);
    rd_port(2'h1, s);
    `CHK("read ctrl", 16'h0002, s[15:0])
    `CHK("readback", 1'b0, readback_on)
    send(8'h3B, 16'h0030);
    chk_gain(3'h3);
    send(8'h00, 16'h0001);
    chk_gain(3'h0);
    wr_port(2'h2, 32'h2);
    repeat (16) @(posedge clk);
    chk_gain(3'h3);
    send(8'h3B, 16'h0050);
    chk_gain(3'h3);
    wr_port(2'h0, 32'h00800000);
    repeat (6) @(posedge clk);
    #1 `CHK("band pin", 1'b1, narrow_band_select)
    wait_idle();
    `CHK("band pin", 1'b0, narrow_band_select)
    wr_port(2'h2, 32'h0);
    repeat (16) @(posedge clk);
    chk_gain(3'h0);
    test_done();
  end
endmodule // tb_serial_config_port
`undef CHK
`default_nettype wire
